// ---- design/slc_sleep_map.vh ----
// constants for the sleep mode controller: control field layout, mode codes,
// wake timing and state codes. definitions only, no logic.
`ifndef SLC_SLEEP_MAP_VH
`define SLC_SLEEP_MAP_VH

// control word layout and reset value
`define SLC_CTRL_W          3
`define SLC_CTRL_RESET      3'h0
`define SLC_CTRL_EN_BIT     0
`define SLC_CTRL_MODE_HI    2
`define SLC_CTRL_MODE_LO    1

// low power state select codes
`define SLC_MODE_IDLE       2'h0
`define SLC_MODE_STANDBY    2'h1
`define SLC_MODE_DEEPEST_LOW_POWER_STATE      2'h2
`define SLC_MODE_RSVD       2'h3

// brown-out active-mode code that asks for a wait on detector ready
`define SLC_BOD_WAIT_CODE   2'h3

// wake time in peripheral clock cycles and counter width
`define SLC_WAKE_CYCLES     3'h6
`define SLC_WAKE_CNT_W      3
`define SLC_WAKE_CNT_ZERO   3'h0
`define SLC_WAKE_CNT_ONE    3'h1

// controller state codes
`define SLC_ST_ACTIVE       3'h0
`define SLC_ST_SLEEP        3'h1
`define SLC_ST_OSC_WAIT     3'h2
`define SLC_ST_COUNT        3'h3
`define SLC_ST_BOD_WAIT     3'h4

// wake source bit positions
`define SLC_WK_W            6
`define SLC_WK_PIN          0
`define SLC_WK_TWI          1
`define SLC_WK_SOF          2
`define SLC_WK_RTC          3
`define SLC_WK_CAPT         4
`define SLC_WK_OTHER        5

// clock domain gate bit positions
`define SLC_DOM_W           6
`define SLC_DOM_CPU         0
`define SLC_DOM_PER         1
`define SLC_DOM_RTC         2
`define SLC_DOM_ADC         3
`define SLC_DOM_PIT         4
`define SLC_DOM_WDT         5

`endif

// ---- design/slc_mode_decode.v ----
// mode decode for the sleep mode controller: which clock domains, clock sources
// and wake sources are live in a given mode. registered outputs.
// assumes mode and run-in-standby inputs are synchronous to clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
`include "slc_sleep_map.vh"

module slc_mode_decode
(
    input  wire                    clk_sys_i,             // peripheral clock
    input  wire                    reset_i,               // sync reset, high
    input  wire                    asleep_i,              // low power state held
    input  wire [1:0]              mode_i,                // latched mode code
    input  wire                    rtc_run_stby_i,        // rtc run in standby
    input  wire                    adc_run_stby_i,        // converter run in standby
    input  wire                    per_run_stby_i,        // peripherals run in standby
    input  wire                    sof_run_stby_i,        // serial run in standby
    input  wire                    main_keep_running_i,   // main osc keep running
    input  wire                    ulp_keep_running_i,    // 32k osc keep running
    input  wire                    ulp_used_i,            // bod or watchdog uses 32k
    output reg  [`SLC_DOM_W-1:0]   dom_en_o,              // clock domain enables
    output reg                     main_osc_en_o,         // main source on
    output reg                     rtc_osc_en_o,          // rtc source on
    output reg                     ulp_osc_en_o,          // 32k source on
    output reg  [`SLC_WK_W-1:0]    wake_allow_o           // allowed wake sources
);

    reg [`SLC_DOM_W-1:0] next_dom;   // next domain enables
    reg                  next_main;  // next main source enable
    reg                  next_rtc;   // next rtc source enable
    reg                  next_ulp;   // next 32k enable
    reg [`SLC_WK_W-1:0]  next_wake;  // next wake mask

    // combinational mode table
    always @*
    begin
        next_dom  = {`SLC_DOM_W{1'b1}};
        next_main = 1'b1;
        next_rtc  = 1'b1;
        next_ulp  = 1'b1;
        next_wake = {`SLC_WK_W{1'b1}};
        if (asleep_i)
        begin
            case (mode_i)
                `SLC_MODE_IDLE:
                begin
                    // only the cpu clock stops, every source may wake      R9
                    next_dom[`SLC_DOM_CPU] = 1'b0;
                end
                `SLC_MODE_STANDBY:
                begin
                    // per, rtc and adc domains kept only where run-in-standby is set; pit and watchdog always run   R10
                    next_dom[`SLC_DOM_CPU] = 1'b0;
                    next_dom[`SLC_DOM_PER] = per_run_stby_i;
                    next_dom[`SLC_DOM_RTC] = rtc_run_stby_i;
                    next_dom[`SLC_DOM_ADC] = adc_run_stby_i;
                    next_main = per_run_stby_i | adc_run_stby_i | main_keep_running_i; // R10 R17
                    next_rtc  = rtc_run_stby_i;                                          // R10
                    // restricted wake set in standby                         R11
                    next_wake[`SLC_WK_SOF]   = sof_run_stby_i;
                    next_wake[`SLC_WK_RTC]   = rtc_run_stby_i;
                    next_wake[`SLC_WK_OTHER] = 1'b0;
                end
                default:
                begin
                    // power-down and reserved: only pit and watchdog run     R12
                    next_dom  = {`SLC_DOM_W{1'b0}};
                    next_dom[`SLC_DOM_PIT] = 1'b1;
                    next_dom[`SLC_DOM_WDT] = 1'b1;
                    // sources off save a kept-running main osc and a used or kept 32k osc  R15 R17
                    next_main = main_keep_running_i;
                    next_rtc  = 1'b0;
                    next_ulp  = ulp_used_i | ulp_keep_running_i;             // R15
                    // pin change and address match only                     R13
                    next_wake = {`SLC_WK_W{1'b0}};
                    next_wake[`SLC_WK_PIN] = 1'b1;
                    next_wake[`SLC_WK_TWI] = 1'b1;
                end
            endcase
        end
    end

    // register the table so the top sees flop outputs
    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            dom_en_o      <= {`SLC_DOM_W{1'b1}};
            main_osc_en_o <= 1'b1;
            rtc_osc_en_o  <= 1'b1;
            ulp_osc_en_o  <= 1'b1;
            wake_allow_o  <= {`SLC_WK_W{1'b1}};
        end
        else
        begin
            dom_en_o      <= next_dom;
            main_osc_en_o <= next_main;
            rtc_osc_en_o  <= next_rtc;
            ulp_osc_en_o  <= next_ulp;
            wake_allow_o  <= next_wake;
        end
    end

endmodule // slc_mode_decode

`default_nettype wire

// ---- design/slc_sleep_controller.v ----
// sleep mode controller top: control word, sleep entry, wake sequencing.
// assumes all inputs are synchronous to clk_sys_i (the peripheral clock) and that
// the cpu holds its state while its clock gate is closed.
//
// Overview of operation
// R1 - active plus idle, standby, power-down states
// R2 - select mode, set enable, then sleep instruction
// R3 - sleeping halts cpu, gates mode's domains
// R4 - interrupt wake runs isr, resumes after sleep
// R5 - any reset ends sleep, restarts from vector
// R6 - register file, sram, peripherals keep contents
// R7 - debug break wakes even without interrupt
// R8 - software enables wake interrupts before sleeping
// R9 - idle stops cpu clock only, all wake
// R10 - standby domains kept by run-in-standby bits
// R11 - standby wake: pin, address, sof, rtc, capture
// R12 - power-down keeps only watchdog and pit
// R13 - power-down wake: pin change, address match
// R14 - wake is six cycles plus osc start
// R15 - power-down: only 32k osc, if used
// R16 - bod code 3 holds wake until ready
// R17 - keep-running holds osc, skips start delay
// R18 - runs on peripheral clock, normal in debug
// R19 - state codes: 0 idle, 1 standby, 2 power-down
// R20 - enable must be one before sleep instruction
// R21 - enable bit 0, mode bits 2:1, reset zero
// R22 - count starts after active clock stable
// R23 - sleep with enable clear is no operation
`timescale 1ns/10ps
`default_nettype none
`include "slc_sleep_map.vh"

module slc_sleep_controller
(
    input  wire                    clk_sys_i,             // peripheral clock  R18
    input  wire                    reset_i,               // any reset source, high
    input  wire                    ctrl_wr_i,             // control word write strobe
    input  wire [`SLC_CTRL_W-1:0]  ctrl_wdata_i,          // control write data
    input  wire                    sleep_instr_i,         // sleep instruction executed
    input  wire [`SLC_WK_W-1:0]    wake_req_i,            // pending enabled interrupts
    input  wire                    debug_break_i,         // debugger break
    input  wire                    rtc_run_stby_i,        // rtc run in standby
    input  wire                    adc_run_stby_i,        // converter run in standby
    input  wire                    per_run_stby_i,        // peripherals run in standby
    input  wire                    sof_run_stby_i,        // serial sof run in standby
    input  wire                    main_keep_running_i,   // main osc keep running
    input  wire                    ulp_keep_running_i,    // 32k osc keep running
    input  wire                    ulp_used_i,            // bod or watchdog on 32k
    input  wire                    main_osc_stable_i,     // main source stable
    input  wire [1:0]              bod_active_cfg_i,      // bod active-mode config
    input  wire                    bod_ready_i,           // bod ready
    output reg  [`SLC_CTRL_W-1:0]  ctrl_rdata_o,          // control word readback
    output reg                     sleeping_o,            // in low power or waking
    output reg                     cpu_run_o,             // cpu clock enable
    output reg                     wake_irq_o,            // wake by interrupt, take isr
    output reg  [`SLC_DOM_W-1:0]   dom_en_o,              // clock domain enables
    output reg                     main_osc_en_o,         // main source enable
    output reg                     rtc_osc_en_o,          // rtc source enable
    output reg                     ulp_osc_en_o,          // 32k source enable
    output reg  [2:0]              state_o                // controller state
);

    // states
    localparam [2:0] ST_ACTIVE   = `SLC_ST_ACTIVE;
    localparam [2:0] ST_SLEEP    = `SLC_ST_SLEEP;
    localparam [2:0] ST_OSC_WAIT = `SLC_ST_OSC_WAIT;
    localparam [2:0] ST_COUNT    = `SLC_ST_COUNT;
    localparam [2:0] ST_BOD_WAIT = `SLC_ST_BOD_WAIT;

    reg                        sleep_enable_bit;        // control enable
    reg [1:0]                  low_power_state_select;  // control mode field
    reg [1:0]                  cur_mode;                // mode latched at entry
    reg [2:0]                  state;                   // controller state
    reg [2:0]                  next_state;              // next controller state
    reg [`SLC_WAKE_CNT_W-1:0]  wake_cnt;                // wake cycles remaining
    reg [`SLC_WAKE_CNT_W-1:0]  next_wake_cnt;           // next wake count
    reg                        by_irq;                  // wake cause was interrupt
    reg                        next_by_irq;             // next wake cause
    wire [`SLC_DOM_W-1:0]      dec_dom;                 // decoded domain enables
    wire                       dec_main;                // decoded main enable
    wire                       dec_rtc;                 // decoded rtc enable
    wire                       dec_ulp;                 // decoded 32k enable
    wire [`SLC_WK_W-1:0]       dec_wake;                // decoded wake mask
    wire                       wake_hit;                // allowed interrupt pending
    wire                       asleep;                  // gating applies

    // a mode whose main source may have been stopped needs the stable wait
    function needs_osc;
        input [1:0] mode;
        input       keep;
        begin
            needs_osc = (mode != `SLC_MODE_IDLE) && !keep; // R14 R17
        end
    endfunction

    assign asleep   = (state == ST_SLEEP);                     // R3
    assign wake_hit = |(wake_req_i & dec_wake);                // R9 R11 R13

    // domain gating for the latched mode
    slc_mode_decode u_decode
    (
        .clk_sys_i           (clk_sys_i),
        .reset_i             (reset_i),
        .asleep_i            (asleep),
        .mode_i              (cur_mode),
        .rtc_run_stby_i      (rtc_run_stby_i),
        .adc_run_stby_i      (adc_run_stby_i),
        .per_run_stby_i      (per_run_stby_i),
        .sof_run_stby_i      (sof_run_stby_i),
        .main_keep_running_i (main_keep_running_i),
        .ulp_keep_running_i  (ulp_keep_running_i),
        .ulp_used_i          (ulp_used_i),
        .dom_en_o            (dec_dom),
        .main_osc_en_o       (dec_main),
        .rtc_osc_en_o        (dec_rtc),
        .ulp_osc_en_o        (dec_ulp),
        .wake_allow_o        (dec_wake)
    );

    // control word; reset clears it, so every reset ends sleep too
    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            sleep_enable_bit       <= 1'b0;                   // R21
            low_power_state_select <= `SLC_MODE_IDLE;         // R21 R19
        end
        else if (ctrl_wr_i)
        begin
            sleep_enable_bit       <= ctrl_wdata_i[`SLC_CTRL_EN_BIT];                    // R21
            low_power_state_select <= ctrl_wdata_i[`SLC_CTRL_MODE_HI:`SLC_CTRL_MODE_LO]; // R21
        end
    end

    // next state logic
    always @*
    begin
        next_state    = state;
        next_wake_cnt = wake_cnt;
        next_by_irq   = by_irq;
        case (state)
            ST_ACTIVE:
            begin
                // only the sleep instruction with enable set enters sleep   R2 R20
                // with enable clear the instruction is a no operation       R23
                if (sleep_instr_i && sleep_enable_bit)
                begin
                    next_state  = ST_SLEEP;                   // R1 R3
                    next_by_irq = 1'b0;
                end
            end
            ST_SLEEP:
            begin
                // debug break wakes even with nothing pending             R7
                if (wake_hit || debug_break_i)
                begin
                    next_by_irq   = wake_hit;                 // R4
                    next_wake_cnt = `SLC_WAKE_CYCLES;         // R14
                    if (needs_osc(cur_mode, main_keep_running_i))
                        next_state = ST_OSC_WAIT;             // R14 R22
                    else
                        next_state = ST_COUNT;                // R17
                end
            end
            ST_OSC_WAIT:
            begin
                // count starts only once the active clock is stable        R22
                if (main_osc_stable_i)
                    next_state = ST_COUNT;
            end
            ST_COUNT:
            begin
                // six peripheral clock cycles                             R14
                next_wake_cnt = wake_cnt - `SLC_WAKE_CNT_ONE;
                if (wake_cnt == `SLC_WAKE_CNT_ONE)
                begin
                    // longer of count and bod ready                        R16
                    if ((bod_active_cfg_i == `SLC_BOD_WAIT_CODE) && !bod_ready_i)
                        next_state = ST_BOD_WAIT;
                    else
                        next_state = ST_ACTIVE;
                end
            end
            ST_BOD_WAIT:
            begin
                if (bod_ready_i)
                    next_state = ST_ACTIVE;                   // R16
            end
            default:
            begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // state registers; reset returns to active, cpu restarts at its vector
    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            state    <= ST_ACTIVE;                            // R5
            cur_mode <= `SLC_MODE_IDLE;
            wake_cnt <= `SLC_WAKE_CNT_ZERO;
            by_irq   <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            wake_cnt <= next_wake_cnt;
            by_irq   <= next_by_irq;
            // mode sampled on entry so mid-sleep writes do not disturb gating
            if (state == ST_ACTIVE)
                cur_mode <= low_power_state_select;           // R2
        end
    end

    // registered outputs; state is only gated, never cleared, so contents hold
    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            ctrl_rdata_o  <= `SLC_CTRL_RESET;                 // R21
            sleeping_o    <= 1'b0;
            cpu_run_o     <= 1'b1;
            wake_irq_o    <= 1'b0;
            dom_en_o      <= {`SLC_DOM_W{1'b1}};
            main_osc_en_o <= 1'b1;
            rtc_osc_en_o  <= 1'b1;
            ulp_osc_en_o  <= 1'b1;
            state_o       <= ST_ACTIVE;
        end
        else
        begin
            ctrl_rdata_o  <= ctrl_wr_i ? ctrl_wdata_i : {low_power_state_select, sleep_enable_bit}; // R21
            sleeping_o    <= (next_state != ST_ACTIVE);
            // cpu halted from entry until the wake count and any bod wait complete  R3 R22 R6
            cpu_run_o     <= (next_state == ST_ACTIVE);
            // one pulse on resume so the core takes the isr first           R4
            wake_irq_o    <= (state != ST_ACTIVE) && (next_state == ST_ACTIVE) && by_irq;
            // domain gates apply while asleep; peripherals and sources
            // stay up once wake has started, so the osc can restart
            dom_en_o      <= asleep ? dec_dom  : {`SLC_DOM_W{1'b1}};  // R3 R12
            main_osc_en_o <= asleep ? dec_main : 1'b1;                // R15 R17
            rtc_osc_en_o  <= asleep ? dec_rtc  : 1'b1;
            ulp_osc_en_o  <= asleep ? dec_ulp  : 1'b1;                // R15
            state_o       <= next_state;
        end
    end

endmodule // slc_sleep_controller

`default_nettype wire

// ---- verification/slc_sleep_asserts.sv ----
// checker for the sleep controller: entry, gating, masks, wake timing.
// assumes it is bound to slc_sleep_controller and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module slc_sleep_asserts
(
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    input wire logic       ctrl_wr_i,
    input wire logic [2:0] ctrl_wdata_i,
    input wire logic       sleep_instr_i,
    input wire logic [5:0] wake_req_i,
    input wire logic       debug_break_i,
    input wire logic       sof_run_stby_i,
    input wire logic       main_keep_running_i,
    input wire logic       main_osc_stable_i,
    input wire logic [1:0] bod_active_cfg_i,
    input wire logic       bod_ready_i,
    input wire logic [2:0] ctrl_rdata_o,
    input wire logic       sleeping_o,
    input wire logic       cpu_run_o,
    input wire logic       wake_irq_o,
    input wire logic [5:0] dom_en_o,
    input wire logic       main_osc_en_o,
    input wire logic [2:0] state_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // masks valid from second sleeping cycle
    property p_enter;
        sleep_instr_i && state_o == 3'h0 && ctrl_rdata_o[0] |=> state_o == 3'h1 && !cpu_run_o && sleeping_o;
    endproperty
    a_enter: assert property (p_enter) else $error("sleep entry missed");
    property p_noop;
        sleep_instr_i && state_o == 3'h0 && !ctrl_rdata_o[0] |=> state_o == 3'h0 && cpu_run_o;
    endproperty
    a_noop: assert property (p_noop) else $error("disabled sleep not ignored");
    property p_idle_gate;
        sleep_instr_i && state_o == 3'h0 && ctrl_rdata_o == 3'h1 |=> ##2 dom_en_o == 6'h3E;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("idle gating wrong");
    property p_pd_gate;
        sleep_instr_i && state_o == 3'h0 && ctrl_rdata_o[2] && ctrl_rdata_o[0] && !main_keep_running_i
            |=> ##2 dom_en_o == 6'h30 && !main_osc_en_o;
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("power-down gating wrong");
    // dom 0x30: power-down, or standby with rtc, adc and per run-in-standby off; these stay masked
    property p_pd_mask;
        state_o == 3'h1 && $past(state_o) == 3'h1 && dom_en_o == 6'h30 && wake_req_i[1:0] == 2'h0
            && !wake_req_i[4] && !(wake_req_i[2] && sof_run_stby_i) && !debug_break_i |=> state_o == 3'h1;
    endproperty
    a_pd_mask: assert property (p_pd_mask) else $error("masked source woke");
    property p_wake6;
        state_o == 3'h1 && $past(state_o) == 3'h1 && wake_req_i[0] && main_keep_running_i
            && bod_active_cfg_i != 2'h3 |=> (state_o == 3'h3 && !cpu_run_o)[*6] ##1 cpu_run_o && wake_irq_o;
    endproperty
    a_wake6: assert property (p_wake6) else $error("wake count wrong");
    property p_break;
        state_o == 3'h1 && $past(state_o) == 3'h1 && debug_break_i |=> ##1 dom_en_o == 6'h3F && !wake_irq_o;
    endproperty
    a_break: assert property (p_break) else $error("break did not wake");
    property p_osc_wait;
        state_o == 3'h2 && !main_osc_stable_i |=> state_o == 3'h2 && !cpu_run_o;
    endproperty
    a_osc_wait: assert property (p_osc_wait) else $error("count before stable");
    property p_bod;
        state_o == 3'h4 && !bod_ready_i |=> state_o == 3'h4 && !cpu_run_o;
    endproperty
    a_bod: assert property (p_bod) else $error("ran before detector ready");
    property p_rdback;
        ctrl_wr_i |=> ctrl_rdata_o == $past(ctrl_wdata_i);
    endproperty
    a_rdback: assert property (p_rdback) else $error("control readback wrong");
    property p_halt;
        sleeping_o != cpu_run_o;
    endproperty
    a_halt: assert property (p_halt) else $error("cpu runs while asleep");
endmodule // slc_sleep_asserts
bind slc_sleep_controller slc_sleep_asserts chk_u (.clk_sys_i, .reset_i, .ctrl_wr_i, .ctrl_wdata_i,
    .sleep_instr_i, .wake_req_i, .debug_break_i, .sof_run_stby_i, .main_keep_running_i, .main_osc_stable_i,
    .bod_active_cfg_i, .bod_ready_i, .ctrl_rdata_o, .sleeping_o, .cpu_run_o, .wake_irq_o, .dom_en_o,
    .main_osc_en_o, .state_o);
`default_nettype wire

// ---- verification/slc_osc_model.sv ----
// main clock source model: stable a few cycles after its request.
// assumes the controller's clock.
`timescale 1ns/10ps
`default_nettype none
module slc_osc_model
#(
    parameter integer DLY = 3          // start-up cycles, short for run time
)
(
    input  wire logic clk_sys_i,       // peripheral clock
    input  wire logic osc_en_i,        // source requested
    input  wire logic keep_i,          // keep-running setting
    output var  logic stable_o         // source stable
);
    integer cnt = 0;                   // cycles since request
    // cold start unless requested or kept running
    always @(posedge clk_sys_i)
    begin
        if (keep_i || (osc_en_i && cnt >= DLY))
            stable_o <= 1'b1;
        else
        begin
            stable_o <= 1'b0;
            cnt <= osc_en_i ? cnt + 1 : 0;
        end
    end
endmodule // slc_osc_model
`default_nettype wire

// ---- verification/slc_sleep_controller_tb_top.sv ----
// testbench for the sleep controller: entry, mode gating, masks, wake timing.
// assumes dut, checker and source model compile first.
`timescale 1ns/10ps
`default_nettype none
module slc_sleep_controller_tb_top;
    logic       clk_sys_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       ctrl_wr_i = 1'b0;
    logic [2:0] ctrl_wdata_i = 3'h0;
    logic       sleep_instr_i = 1'b0;
    logic [5:0] wake_req_i = 6'h00;
    logic       brk = 1'b0;
    logic [3:0] run_stby = 4'h0;       // rtc, adc, per, sof
    logic       main_keep = 1'b0;
    logic       ulp_keep = 1'b0;
    logic       ulp_used = 1'b0;
    logic       main_stable;
    logic [1:0] bod_cfg = 2'h0;
    logic       bod_ready = 1'b1;
    logic [2:0] ctrl_rdata_o;
    logic       sleeping_o, cpu_run_o, wake_irq_o, main_osc_en_o, rtc_osc_en_o, ulp_osc_en_o;
    logic [5:0] dom_en_o;
    logic [2:0] state_o;
    logic [5:0] dexp [4] = '{6'h3E, 6'h34, 6'h30, 6'h30};  // gating per mode, rtc run only
    integer     n_fail = 0;
    integer     samples_checked = 0;
    integer     cycles = 0;
    integer     n;
    always #5 clk_sys_i = ~clk_sys_i;
    slc_sleep_controller dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ctrl_wr_i(ctrl_wr_i),
        .ctrl_wdata_i(ctrl_wdata_i), .sleep_instr_i(sleep_instr_i), .wake_req_i(wake_req_i),
        .debug_break_i(brk), .rtc_run_stby_i(run_stby[0]), .adc_run_stby_i(run_stby[1]),
        .per_run_stby_i(run_stby[2]), .sof_run_stby_i(run_stby[3]), .main_keep_running_i(main_keep),
        .ulp_keep_running_i(ulp_keep), .ulp_used_i(ulp_used), .main_osc_stable_i(main_stable),
        .bod_active_cfg_i(bod_cfg), .bod_ready_i(bod_ready), .ctrl_rdata_o(ctrl_rdata_o),
        .sleeping_o(sleeping_o), .cpu_run_o(cpu_run_o), .wake_irq_o(wake_irq_o), .dom_en_o(dom_en_o),
        .main_osc_en_o(main_osc_en_o), .rtc_osc_en_o(rtc_osc_en_o), .ulp_osc_en_o(ulp_osc_en_o), .state_o(state_o));
    slc_osc_model osc_u (.clk_sys_i(clk_sys_i), .osc_en_i(main_osc_en_o), .keep_i(main_keep),
        .stable_o(main_stable));
    // inputs move 1 ns after the edge
    task cyc(input integer k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // enable first, sleep one edge later; returns at the gating edge
    task go_sleep(input logic [1:0] mode);
        ctrl_wr_i = 1'b1;
        ctrl_wdata_i = {mode, 1'b1};
        cyc(1);
        ctrl_wr_i = 1'b0;
        sleep_instr_i = 1'b1;
        cyc(1);
        sleep_instr_i = 1'b0;
        cyc(2);
    endtask
    // hold the source until cpu runs, bounded; n counts edges
    task wake_by(input logic [5:0] src, input logic b);
        wake_req_i = src;
        brk = b;
        n = 0;
        while (cpu_run_o !== 1'b1 && n < 200)
        begin
            cyc(1);
            n++;
        end
        wake_req_i = 6'h00;
        brk = 1'b0;
    endtask
    // masked sources held, then an allowed one
    task t_mask(input logic [1:0] mode, input logic [5:0] blk, input logic [5:0] ok);
        go_sleep(mode);
        wake_req_i = blk;
        cyc(6);
        chk(state_o, 8'h01);
        wake_by(ok, 1'b0);
        chk({n > 8, cpu_run_o}, 8'h03);
        $display("mask test mode %0d done", mode);
    endtask
    task t_modes;
        run_stby = 4'h1;
        for (int m = 0; m < 4; m++)
        begin
            go_sleep(m[1:0]);
            chk(dom_en_o, dexp[m]);
            if (m > 1)
                chk({main_osc_en_o, rtc_osc_en_o, ulp_osc_en_o}, 8'h00);
            wake_by(6'h01, 1'b0);
            chk({dom_en_o, wake_irq_o, cpu_run_o}, 8'hFF);
            if (m == 0)
                chk(n, 8'h07);
        end
        run_stby = 4'h0;
        $display("mode test done");
    endtask
    task t_misc;
        chk({ctrl_rdata_o, state_o, cpu_run_o, sleeping_o}, 8'h02);
        ctrl_wr_i = 1'b1;
        ctrl_wdata_i = 3'h4;
        cyc(1);
        ctrl_wr_i = 1'b0;
        sleep_instr_i = 1'b1;
        cyc(1);
        sleep_instr_i = 1'b0;
        cyc(2);
        chk({ctrl_rdata_o, state_o, cpu_run_o, sleeping_o}, 8'h82);
        go_sleep(2'h2);
        wake_by(6'h00, 1'b1);
        chk({wake_irq_o, cpu_run_o}, 8'h01);
        main_keep = 1'b1;
        go_sleep(2'h2);
        wake_by(6'h01, 1'b0);
        chk(n, 8'h07);
        main_keep = 1'b0;
        $display("basic test done");
    endtask
    task t_bod_reset;
        bod_cfg = 2'h3;
        bod_ready = 1'b0;
        go_sleep(2'h0);
        wake_req_i = 6'h01;
        cyc(12);
        chk({state_o, cpu_run_o}, 8'h08);
        bod_ready = 1'b1;
        wake_by(6'h01, 1'b0);
        chk(cpu_run_o, 8'h01);
        bod_cfg = 2'h0;
        go_sleep(2'h2);
        reset_i = 1'b1;
        cyc(2);
        reset_i = 1'b0;
        chk({ctrl_rdata_o, state_o, cpu_run_o, sleeping_o}, 8'h02);
        chk(dom_en_o, 8'h3F);
        cyc(1);
        $display("detector and reset test done");
    endtask
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            end_of_test;
        end
    end
    initial
    begin
        cyc(2);
        reset_i = 1'b0;
        t_misc;
        t_modes;
        t_mask(2'h1, 6'h2C, 6'h10);
        t_mask(2'h2, 6'h3C, 6'h02);
        t_bod_reset;
        end_of_test;
    end
endmodule // slc_sleep_controller_tb_top
`default_nettype wire
